// >>> rtl/correlator_control_regs.v
// host-visible control and readout registers of the correlator module
`timescale 1ns/100ps
`default_nettype none
`include "correlator_control_regs_regs.vh"

// What this block does
// - writing 1 to advance bit steps serial-number PROM to its next bit
// - reading advance bit returns current serial PROM data level
// - PROM reset, advance and read act only while serial read enable set
// - writing 1 to program bit pulses selected chip done/program line low
// - reading program bit returns present done/program line level
// - writing 1 to clock bit emits one clock, capturing shared data bit
// - program, clock and reset pulses go to the chip target select picks
// - writing 1 to configuration reset bit sends one reset pulse
// - master-sync high drives sync bus as master; low leaves bus undriven
// - low-half register gives low 16 bits of selected result, read first
// - high-half register gives upper 16 bits, read right after low half
// - output chip select steers result reads to chip 0 or chip 1
// - bus address loads at power-up and on reload write; reload reads meaningless
// - test-data enable swaps correlator data for pseudo-random values on both paths
// - generator restarts on DMA start with low 10 address bits zero, or read start
// - readout-path bit 1 gives data to host bus, 0 to DMA transfer
// - bus address register shows slot in bits 5-7, ident in bits 8-15
// - unused output control bits store whatever the host writes
// - shared bit enables serial reading and supplies configuration data bit
// - target select low picks DMA interface chip, high picks sampler chip
// - writing 1 to PROM reset bit resets the serial-number PROM
module correlator_control_regs #(
	parameter                  PULSE_CYCLES = `CFG_PULSE_CYCLES,
	parameter                  SYNC_BITS    = 16
) (
	input  wire                clk,
	input  wire                reset,
	input  wire [14:0]         bus_addr,
	input  wire [15:0]         bus_wdata_in,
	output reg  [15:0]         bus_rdata_out,
	output reg                 bus_rdata_oe,
	input  wire                bus_strobe_n,
	input  wire                bus_write_n,
	output reg                 bus_ack,
	output reg                 prom_reset_pulse,
	output reg                 prom_advance_pulse,
	input  wire                prom_data,
	output reg                 config_data,
	output reg  [1:0]          config_clock,
	output reg  [1:0]          config_reset,
	input  wire [1:0]          config_done_program_line_in,
	output wire [1:0]          config_done_program_line_out,
	output reg  [1:0]          config_done_program_line_oe,
	input  wire                sync_signal,
	output reg                 sync_bus_out,
	output reg                 sync_bus_oe,
	input  wire [31:0]         corr0_result,
	input  wire [31:0]         corr1_result,
	input  wire                host_read_start,
	input  wire                dma_start,
	input  wire [15:0]         dma_start_addr,
	input  wire                dma_word_take,
	output reg  [31:0]         dma_data,
	output reg                 dma_path_enable,
	input  wire [2:0]          slot_position,
	input  wire [7:0]          block_ident,
	output reg  [15:0]         data_clock_gen_one
);

	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_ACK  = 2'b10;
	// strobe, write and done lines idle high; other pins idle low
	localparam [SYNC_BITS-1:0] PIN_IDLE = `PIN_IDLE;

	// pin inputs gathered for the three-stage synchroniser
	wire [SYNC_BITS-1:0] pin_raw;
	reg  [SYNC_BITS-1:0] pin_s1_reg;
	reg  [SYNC_BITS-1:0] pin_s2_reg;
	reg  [SYNC_BITS-1:0] pin_s3_reg;
	reg  [SYNC_BITS-1:0] pin_reg;

	wire                 strobe_n_f;
	wire                 write_n_f;
	wire [1:0]           done_f;
	wire                 prom_data_f;
	wire [2:0]           slot_f;
	wire [7:0]           ident_f;

	reg  [1:0]           state_reg;
	reg  [1:0]           state_next;
	wire                 access;
	wire                 do_write;
	wire                 do_read;

	reg  [15:0]          cc_reg;
	reg  [15:0]          oc_reg;
	reg  [15:0]          dcg_reg;
	reg  [15:0]          bus_addr_reg;
	reg                  addr_load_reg;
	reg  [`SETTLE_CNT_W-1:0] settle_cnt_reg;
	reg  [31:0]          capture_reg;

	reg  [`PULSE_CNT_W-1:0] pulse_cnt_reg;
	reg                  p_prom_reset_reg;
	reg                  p_prom_adv_reg;
	reg                  p_program_reg;
	reg                  p_clock_reg;
	reg                  p_reset_reg;
	reg                  p_target_reg;

	wire                 serial_en;
	wire                 host_path;
	wire                 test_data;
	wire [31:0]          corr_sel;
	wire [31:0]          source;
	wire [31:0]          prng_value;
	wire                 prng_restart;
	wire                 prng_step;
	wire                 low_read;
	reg  [15:0]          rdata_next;
	wire                 cc_hit;
	wire                 oc_hit;
	wire                 any_pulse;

	assign pin_raw = {block_ident, slot_position, prom_data, config_done_program_line_in,
		bus_write_n, bus_strobe_n};

	genvar gi;
	generate
		for (gi = 0; gi < SYNC_BITS; gi = gi + 1) begin : g_sync
			always @(posedge clk or posedge reset) begin
				if (reset) begin
					pin_s1_reg[gi] <= PIN_IDLE[gi];
					pin_s2_reg[gi] <= PIN_IDLE[gi];
					pin_s3_reg[gi] <= PIN_IDLE[gi];
					pin_reg[gi]    <= PIN_IDLE[gi];
				end else begin
					pin_s1_reg[gi] <= pin_raw[gi];
					pin_s2_reg[gi] <= pin_s1_reg[gi];
					pin_s3_reg[gi] <= pin_s2_reg[gi];
					if (pin_s2_reg[gi] == pin_s3_reg[gi]) begin
						pin_reg[gi] <= pin_s3_reg[gi];
					end
				end
			end
		end
	endgenerate

	// stages reset to the idle level, so no false strobe or done edge follows reset
	assign strobe_n_f  = pin_reg[0];
	assign write_n_f   = pin_reg[1];
	assign done_f      = pin_reg[3:2];
	assign prom_data_f = pin_reg[4];
	assign slot_f      = pin_reg[7:5];
	assign ident_f     = pin_reg[15:8];

	// address and write data are not synchronised: they are stable long before the strobe is seen
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (!strobe_n_f && addr_load_reg == 1'b0) begin
					state_next = ST_ACK;
				end
			end
			ST_ACK: begin
				if (strobe_n_f) begin
					state_next = ST_IDLE;
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	assign access   = (state_reg == ST_IDLE) && (state_next == ST_ACK);
	assign do_write = access && !write_n_f;
	assign do_read  = access && write_n_f;
	assign cc_hit   = do_write && (bus_addr == `OFS_CONFIG_CONTROL);
	assign oc_hit   = do_write && (bus_addr == `OFS_OUTPUT_CONTROL);

	assign serial_en = cc_reg[`CC_SERIAL_DATA];
	assign host_path = oc_reg[`OC_HOST_PATH];
	assign test_data = oc_reg[`OC_TEST_DATA];
	assign corr_sel  = oc_reg[`OC_CHIP_SELECT] ? corr1_result : corr0_result;
	assign source    = test_data ? prng_value : corr_sel;
	assign low_read  = do_read && (bus_addr == `OFS_RESULT_LOW) && host_path;

	assign prng_restart = host_read_start ||
		(dma_start && dma_start_addr[`DMA_RESTART_BITS-1:0] == {`DMA_RESTART_BITS{1'b0}});
	assign prng_step = test_data && (host_path ? low_read : dma_word_take);

	prng_source #(
		.WIDTH   (`PRNG_WIDTH),
		.SEED    (`PRNG_SEED)
	) u_prng (
		.clk     (clk),
		.reset   (reset),
		.restart (prng_restart),
		.step    (prng_step),
		.value   (prng_value)
	);

	always @* begin
		rdata_next = 16'h0000;
		case (bus_addr)
			`OFS_CONFIG_CONTROL: begin
				rdata_next = cc_reg & `CC_STORE_MASK;
				rdata_next[`CC_PROM_ADVANCE] = serial_en & prom_data_f;
				rdata_next[`CC_CONFIG_PROGRAM] = done_f[cc_reg[`CC_TARGET_SELECT]];
			end
			`OFS_RESULT_LOW:     rdata_next = host_path ? source[15:0] : 16'h0000;
			`OFS_RESULT_HIGH:    rdata_next = host_path ? capture_reg[31:16] : 16'h0000;
			`OFS_OUTPUT_CONTROL: rdata_next = oc_reg & `OC_STORE_MASK;
			`OFS_BUS_ADDRESS:    rdata_next = bus_addr_reg;
			`OFS_DCG_ONE:        rdata_next = dcg_reg;
			default:             rdata_next = 16'h0000;
		endcase
	end

	// bus handshake: ack and read drive hold until the host lifts its strobe
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg     <= ST_IDLE;
			bus_ack       <= 1'b0;
			bus_rdata_oe  <= 1'b0;
			bus_rdata_out <= 16'h0000;
		end else begin
			state_reg <= state_next;
			bus_ack   <= (state_next == ST_ACK);
			if (do_read) begin
				bus_rdata_out <= rdata_next;
				bus_rdata_oe  <= 1'b1;
			end else if (state_next == ST_IDLE) begin
				bus_rdata_oe  <= 1'b0;
			end
		end
	end

	// register storage; pulse bits are not stored, they start the pulse engine
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			cc_reg      <= `CC_RESET_VALUE;
			oc_reg      <= `OC_RESET_VALUE;
			dcg_reg     <= `DCG_RESET_VALUE;
			capture_reg <= 32'h0000_0000;
		end else begin
			if (cc_hit) begin
				cc_reg <= bus_wdata_in & `CC_STORE_MASK;
			end
			if (oc_hit) begin
				oc_reg <= bus_wdata_in & `OC_STORE_MASK;
			end
			if (do_write && bus_addr == `OFS_DCG_ONE) begin
				dcg_reg <= bus_wdata_in;
			end
			if (low_read) begin
				capture_reg <= source;
			end
		end
	end

	// bus address is loaded once after reset release and again on each reload write
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			addr_load_reg  <= 1'b1;
			settle_cnt_reg <= `ADDR_SETTLE_CYCLES;
			bus_addr_reg   <= 16'h0000;
		end else begin
			// the first load waits until the switch pins have passed the synchroniser
			if (settle_cnt_reg != {`SETTLE_CNT_W{1'b0}}) begin
				settle_cnt_reg <= settle_cnt_reg - {{(`SETTLE_CNT_W-1){1'b0}}, 1'b1};
			end else if (addr_load_reg) begin
				bus_addr_reg  <= {ident_f, slot_f, 5'h00};
				addr_load_reg <= 1'b0;
			end
			if (oc_hit && bus_wdata_in[`OC_RELOAD_ADDRESS]) begin
				addr_load_reg <= 1'b1;
			end
		end
	end

	assign any_pulse = p_prom_reset_reg | p_prom_adv_reg | p_program_reg | p_clock_reg | p_reset_reg;

	// one pulse timer serves every strobe; a new config control write restarts it
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			pulse_cnt_reg    <= {`PULSE_CNT_W{1'b0}};
			p_prom_reset_reg <= 1'b0;
			p_prom_adv_reg   <= 1'b0;
			p_program_reg    <= 1'b0;
			p_clock_reg      <= 1'b0;
			p_reset_reg      <= 1'b0;
			p_target_reg     <= 1'b0;
		end else if (cc_hit) begin
			pulse_cnt_reg    <= PULSE_CYCLES[`PULSE_CNT_W-1:0];
			p_prom_reset_reg <= bus_wdata_in[`CC_PROM_RESET] & bus_wdata_in[`CC_SERIAL_DATA];
			p_prom_adv_reg   <= bus_wdata_in[`CC_PROM_ADVANCE] & bus_wdata_in[`CC_SERIAL_DATA];
			p_program_reg    <= bus_wdata_in[`CC_CONFIG_PROGRAM];
			p_clock_reg      <= bus_wdata_in[`CC_CONFIG_CLOCK];
			p_reset_reg      <= bus_wdata_in[`CC_CONFIG_RESET];
			p_target_reg     <= bus_wdata_in[`CC_TARGET_SELECT];
		end else if (any_pulse) begin
			if (pulse_cnt_reg == {{(`PULSE_CNT_W-1){1'b0}}, 1'b1}) begin
				p_prom_reset_reg <= 1'b0;
				p_prom_adv_reg   <= 1'b0;
				p_program_reg    <= 1'b0;
				p_clock_reg      <= 1'b0;
				p_reset_reg      <= 1'b0;
			end
			pulse_cnt_reg <= pulse_cnt_reg - {{(`PULSE_CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// done/program is open drain: only ever pulled low, the chip releases it high
	assign config_done_program_line_out = 2'b00;

	// config data follows bit 0 of every config control write, so it is steady before the clock edge only when an earlier write set it
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			prom_reset_pulse            <= 1'b0;
			prom_advance_pulse          <= 1'b0;
			config_data                 <= 1'b0;
			config_clock                <= 2'b00;
			config_reset                <= 2'b00;
			config_done_program_line_oe <= 2'b00;
		end else begin
			prom_reset_pulse   <= p_prom_reset_reg;
			prom_advance_pulse <= p_prom_adv_reg;
			config_data        <= cc_reg[`CC_SERIAL_DATA];
			// target low is the DMA interface chip (index 0), high the sampler chip (index 1)
			config_clock <= {p_clock_reg & p_target_reg, p_clock_reg & ~p_target_reg};
			config_reset <= {p_reset_reg & p_target_reg, p_reset_reg & ~p_target_reg};
			config_done_program_line_oe <= {p_program_reg & p_target_reg,
				p_program_reg & ~p_target_reg};
		end
	end

	// no interlock between modules: two masters would both drive the sync bus
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			sync_bus_out <= 1'b0;
			sync_bus_oe  <= 1'b0;
		end else begin
			sync_bus_out <= sync_signal;
			sync_bus_oe  <= cc_reg[`CC_MASTER_SYNC];
		end
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			dma_data           <= 32'h0000_0000;
			dma_path_enable    <= 1'b0;
			data_clock_gen_one <= `DCG_RESET_VALUE;
		end else begin
			dma_data           <= source;
			dma_path_enable    <= ~host_path;
			data_clock_gen_one <= dcg_reg;
		end
	end

endmodule // correlator_control_regs

`default_nettype wire

// >>> rtl/correlator_control_regs_regs.vh
// register offsets, field positions, reset values and timing counts of the correlator control block
`ifndef CORRELATOR_CONTROL_REGS_REGS_VH
`define CORRELATOR_CONTROL_REGS_REGS_VH

`define ADDR_W              15
`define DATA_W              16

`define OFS_CONFIG_CONTROL  15'h0004
`define OFS_RESULT_LOW      15'h0008
`define OFS_RESULT_HIGH     15'h0009
`define OFS_OUTPUT_CONTROL  15'h000A
`define OFS_BUS_ADDRESS     15'h000B
`define OFS_DCG_ONE         15'h000C

`define CC_SERIAL_DATA      0
`define CC_TARGET_SELECT    1
`define CC_PROM_RESET       2
`define CC_PROM_ADVANCE     3
`define CC_CONFIG_PROGRAM   4
`define CC_CONFIG_CLOCK     5
`define CC_CONFIG_RESET     6
`define CC_MASTER_SYNC      7
`define CC_STORE_MASK       16'hFF83
`define CC_RESET_VALUE      16'h0000

`define OC_CHIP_SELECT      0
`define OC_RELOAD_ADDRESS   1
`define OC_TEST_DATA        2
`define OC_HOST_PATH        3
`define OC_STORE_MASK       16'hFFFD
`define OC_RESET_VALUE      16'h0000

`define DCG_RESET_VALUE     16'h0000

`define BA_SLOT_LSB         5
`define BA_IDENT_LSB        8

`define DMA_RESTART_BITS    10
`define PRNG_WIDTH          32
`define PRNG_SEED           32'h0000_0001

`define CLK_PERIOD_NS       25
`define CFG_PULSE_NS        100
`define CFG_PULSE_CYCLES    ((`CFG_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_CNT_W         8
`define ADDR_SETTLE_CYCLES  3'h5
`define SETTLE_CNT_W        3
`define PIN_IDLE            16'h000F

`endif

// >>> rtl/prng_source.v
// pseudo-random test pattern generator used in place of correlator results
`timescale 1ns/100ps
`default_nettype none

module prng_source #(
	parameter                  WIDTH = 32,
	parameter [WIDTH-1:0]      SEED  = 1
) (
	input  wire                clk,
	input  wire                reset,
	input  wire                restart,
	input  wire                step,
	output reg  [WIDTH-1:0]    value
);

	wire feedback;

	// taps give a maximal sequence for the 32-bit default width
	assign feedback = value[WIDTH-1] ^ value[21] ^ value[1] ^ value[0];

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			value <= SEED;
		end else if (restart) begin
			value <= SEED;
		end else if (step) begin
			value <= {value[WIDTH-2:0], feedback};
		end
	end

endmodule // prng_source

`default_nettype wire

// >>> verification/chip_prom_model.sv
// serial number prom and the two configurable chips seen from the block
`timescale 1ns/100ps
`default_nettype none
module chip_prom_model #(
	parameter [7:0] SERIAL = 8'h00,
	parameter       BITS   = 4
) (
	input  wire logic       prom_reset_pulse,
	input  wire logic       prom_advance_pulse,
	output wire logic       prom_data,
	input  wire logic       config_data,
	input  wire logic [1:0] config_clock,
	input  wire logic [1:0] config_oe,
	output wire logic [1:0] done_line,
	output var  logic [7:0] shifted
);
	int         idx = 0;
	int         cnt [2] = '{0, 0};
	logic [1:0] done = 2'b11;
	initial shifted = 8'h00;
	always @(posedge prom_reset_pulse) idx = 0;
	always @(posedge prom_advance_pulse) idx = idx + 1;
	assign prom_data = SERIAL[idx[2:0]];
	for (genvar i = 0; i < 2; i++) begin : g_chip
		always @(posedge config_oe[i]) begin
			done[i] = 1'b0;
			cnt[i] = 0;
		end
		always @(posedge config_clock[i]) begin
			shifted = {shifted[6:0], config_data};
			cnt[i] = cnt[i] + 1;
			if (cnt[i] == BITS) done[i] = 1'b1;
		end
	end
	// pull-up: line reads high unless a chip or the block holds it low
	assign done_line = done & ~config_oe;
endmodule // chip_prom_model
`default_nettype wire

// >>> verification/correlator_control_regs_props.sv
// port assertions of the correlator control block
`timescale 1ns/100ps
`default_nettype none
module correlator_control_regs_props #(
	parameter PULSE_CYCLES = 4
) (
	input wire logic       clk,
	input wire logic       reset,
	input wire logic       bus_strobe_n,
	input wire logic       bus_ack,
	input wire logic       bus_rdata_oe,
	input wire logic       prom_reset_pulse,
	input wire logic       prom_advance_pulse,
	input wire logic       config_data,
	input wire logic [1:0] config_clock,
	input wire logic [1:0] config_reset,
	input wire logic [1:0] config_done_program_line_out,
	input wire logic [1:0] config_done_program_line_oe,
	input wire logic       sync_signal,
	input wire logic       sync_bus_out
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	logic [7:0] len_reg;
	wire        any_pulse;
	assign any_pulse = prom_reset_pulse | prom_advance_pulse | (|config_clock) | (|config_reset)
		| (|config_done_program_line_oe);
	// all pulses of one write run together, so one counter serves them
	always @(posedge clk or posedge reset) begin
		if (reset) len_reg <= 8'h00;
		else if (any_pulse) len_reg <= len_reg + 8'h01;
		else len_reg <= 8'h00;
	end
	sequence s_strobe_held;
		!bus_strobe_n [*7];
	endsequence
	sequence s_strobe_idle;
		bus_strobe_n [*8];
	endsequence
	a_pulse_length: assert property ($fell(any_pulse) |-> len_reg == PULSE_CYCLES)
		else $error("pulse length wrong");
	a_target_one_hot: assert property (config_clock != 2'b11 && config_reset != 2'b11
		&& config_done_program_line_oe != 2'b11) else $error("pulse sent to both chips");
	a_prom_reset_enabled: assert property ($rose(prom_reset_pulse) |-> config_data)
		else $error("prom reset without enable");
	a_prom_step_enabled: assert property ($rose(prom_advance_pulse) |-> config_data)
		else $error("prom advance without enable");
	a_open_drain_low: assert property (config_done_program_line_out == 2'b00)
		else $error("done line driven high");
	a_sync_copy: assert property (!$past(reset) |-> sync_bus_out == $past(sync_signal))
		else $error("sync output not the sync source");
	a_pulse_on_write: assert property ($rose(any_pulse) |-> bus_ack && !bus_strobe_n)
		else $error("pulse outside a write");
	a_read_in_ack: assert property (bus_rdata_oe |-> bus_ack)
		else $error("read data without ack");
	a_ack_in_time: assert property (s_strobe_held |-> bus_ack)
		else $error("ack late");
	a_ack_released: assert property (s_strobe_idle |-> !bus_ack && !bus_rdata_oe)
		else $error("ack held after strobe");
endmodule // correlator_control_regs_props
`default_nettype wire

// >>> verification/tb.sv
// self-checking bench of the correlator control block
`timescale 1ns/100ps
`default_nettype none
`include "correlator_control_regs_regs.vh"
module tb;
	localparam logic [7:0] SERIAL = 8'hB5;
	logic        clk = 0, reset = 1, clr = 0, oe_q = 0, d;
	logic [14:0] bus_addr = 0;
	logic [15:0] bus_wdata_in = 0, r;
	logic        bus_strobe_n = 1, bus_write_n = 1, sync_signal = 0;
	logic        host_read_start = 0, dma_start = 0, dma_word_take = 0;
	logic [15:0] dma_start_addr = 0;
	logic [31:0] corr0_result = 0, corr1_result = 0, v0, v1, sel;
	logic [2:0]  slot_position = 3'h5;
	logic [7:0]  block_ident = 8'hA6, seen = 0, sent;
	wire  [15:0] bus_rdata_out, data_clock_gen_one;
	wire         bus_rdata_oe, bus_ack, prom_reset_pulse, prom_advance_pulse, prom_data, config_data;
	wire  [1:0]  config_clock, config_reset, done_in, done_out, done_oe;
	wire         sync_bus_out, sync_bus_oe, dma_path_enable;
	wire  [31:0] dma_data;
	wire  [7:0]  shifted;
	logic [15:0] exp_q [$];
	int          fails = 0, num_checks = 0;
	correlator_control_regs #(.PULSE_CYCLES(4)) correlator_control_regs_inst (.clk(clk), .reset(reset),
		.bus_addr(bus_addr), .bus_wdata_in(bus_wdata_in), .bus_rdata_out(bus_rdata_out),
		.bus_rdata_oe(bus_rdata_oe), .bus_strobe_n(bus_strobe_n), .bus_write_n(bus_write_n),
		.bus_ack(bus_ack), .prom_reset_pulse(prom_reset_pulse), .prom_advance_pulse(prom_advance_pulse),
		.prom_data(prom_data), .config_data(config_data), .config_clock(config_clock),
		.config_reset(config_reset), .config_done_program_line_in(done_in),
		.config_done_program_line_out(done_out), .config_done_program_line_oe(done_oe),
		.sync_signal(sync_signal), .sync_bus_out(sync_bus_out), .sync_bus_oe(sync_bus_oe),
		.corr0_result(corr0_result), .corr1_result(corr1_result), .host_read_start(host_read_start),
		.dma_start(dma_start), .dma_start_addr(dma_start_addr), .dma_word_take(dma_word_take),
		.dma_data(dma_data), .dma_path_enable(dma_path_enable), .slot_position(slot_position),
		.block_ident(block_ident), .data_clock_gen_one(data_clock_gen_one));
	chip_prom_model #(.SERIAL(SERIAL)) chip_prom_model_inst (.prom_reset_pulse(prom_reset_pulse),
		.prom_advance_pulse(prom_advance_pulse), .prom_data(prom_data), .config_data(config_data),
		.config_clock(config_clock), .config_oe(done_oe), .done_line(done_in), .shifted(shifted));
	initial forever #12.5 clk = ~clk;
	always @(posedge clk) sync_signal <= $urandom;
	always @(posedge clk) seen <= (clr ? 8'h00 : seen) | {done_oe, config_reset, config_clock,
		prom_advance_pulse, prom_reset_pulse};
	task automatic check_reg(input string what, input logic [15:0] e, input logic [15:0] s);
		num_checks++;
		if (s !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic check_pin(input string what, input logic [31:0] e, input logic [31:0] s);
		num_checks++;
		if (s !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", what, e, s);
		end
	endtask
	always @(posedge clk) begin
		oe_q <= bus_rdata_oe;
		if (bus_rdata_oe && !oe_q && exp_q.size() > 0) check_reg("read data", exp_q.pop_front(), bus_rdata_out);
		else if (bus_rdata_oe && !oe_q) begin
			fails++;
			$display("Error read data expected none seen %h", bus_rdata_out);
		end
	end
	task automatic wait_ack(input logic lvl);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (bus_ack !== lvl && n < 40);
		if (bus_ack !== lvl) begin
			fails++;
			$display("Error bus ack expected %b seen %b", lvl, bus_ack);
		end
	endtask
	task automatic bus_cycle(input logic wr, input logic [14:0] a, input logic [15:0] dat);
		@(posedge clk);
		bus_addr <= a;
		bus_wdata_in <= dat;
		bus_write_n <= !wr;
		bus_strobe_n <= 1'b0;
		wait_ack(1'b1);
		repeat (2) @(posedge clk);
		bus_strobe_n <= 1'b1;
		bus_write_n <= 1'b1;
		bus_wdata_in <= $urandom; // released lines show a changing pattern
		wait_ack(1'b0);
		repeat (3) @(posedge clk);
	endtask
	task automatic wr(input logic [14:0] a, input logic [15:0] dat);
		bus_cycle(1'b1, a, dat);
	endtask
	task automatic rd(input logic [14:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		bus_cycle(1'b0, a, 16'h0000);
	endtask
	task automatic clear_seen;
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
	endtask
	task end_of_test;
		if (fails == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		#(25 * 20000);
		fails++;
		end_of_test();
	end
	initial begin
		void'($urandom(79));
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		repeat (10) @(posedge clk);
		rd(`OFS_OUTPUT_CONTROL, 16'h0000);
		rd(`OFS_DCG_ONE, 16'h0000);
		rd(`OFS_BUS_ADDRESS, {8'hA6, 3'h5, 5'h00});
		rd(15'h0005, 16'h0000);
		rd(`OFS_CONFIG_CONTROL, 16'h0010);
		r = $urandom;
		wr(`OFS_DCG_ONE, r);
		rd(`OFS_DCG_ONE, r);
		check_pin("dcg pins", r, data_clock_gen_one);
		wr(`OFS_OUTPUT_CONTROL, r | 16'h0002);
		rd(`OFS_OUTPUT_CONTROL, r & 16'hFFFD);
		slot_position <= 3'h2;
		block_ident <= r[15:8];
		rd(`OFS_BUS_ADDRESS, {8'hA6, 3'h5, 5'h00});
		wr(`OFS_OUTPUT_CONTROL, 16'h0002);
		rd(`OFS_BUS_ADDRESS, {r[15:8], 3'h2, 5'h00});
		for (int i = 0; i < 2; i++) begin
			v0 = $urandom;
			v1 = $urandom;
			corr0_result <= v0;
			corr1_result <= v1;
			sel = i ? v1 : v0;
			wr(`OFS_OUTPUT_CONTROL, 16'h0008 | i);
			rd(`OFS_RESULT_LOW, sel[15:0]);
			corr0_result <= ~v0;
			corr1_result <= ~v1;
			rd(`OFS_RESULT_HIGH, sel[31:16]);
		end
		wr(`OFS_OUTPUT_CONTROL, 16'h0000);
		rd(`OFS_RESULT_LOW, 16'h0000);
		check_pin("dma path", 32'h1, dma_path_enable);
		check_pin("dma data", ~v0, dma_data);
		wr(`OFS_OUTPUT_CONTROL, 16'h000C);
		check_pin("dma path", 32'h0, dma_path_enable);
		host_read_start <= 1'b1;
		@(posedge clk);
		host_read_start <= 1'b0;
		rd(`OFS_RESULT_LOW, 16'h0001);
		rd(`OFS_RESULT_HIGH, 16'h0000);
		rd(`OFS_RESULT_LOW, 16'h0003);
		wr(`OFS_OUTPUT_CONTROL, 16'h0004);
		dma_start_addr <= 16'hFC00;
		dma_start <= 1'b1;
		@(posedge clk);
		dma_start <= 1'b0;
		dma_word_take <= 1'b1;
		@(posedge clk);
		dma_word_take <= 1'b0;
		dma_start_addr <= 16'h0001;
		dma_start <= 1'b1;
		@(posedge clk);
		dma_start <= 1'b0;
		repeat (3) @(posedge clk);
		check_pin("prng after step", 32'h3, dma_data);
		wr(`OFS_CONFIG_CONTROL, 16'h0080);
		check_pin("sync drive", 32'h1, sync_bus_oe);
		wr(`OFS_CONFIG_CONTROL, 16'h0000);
		check_pin("sync drive", 32'h0, sync_bus_oe);
		// no sampler bus traffic in this bench while the serial number is read
		wr(`OFS_CONFIG_CONTROL, 16'h0005);
		for (int i = 0; i < 4; i++) begin
			rd(`OFS_CONFIG_CONTROL, {11'h000, 1'b1, SERIAL[i], 3'b001});
			wr(`OFS_CONFIG_CONTROL, 16'h0009);
		end
		clear_seen();
		wr(`OFS_CONFIG_CONTROL, 16'h0008);
		check_pin("prom without enable", 32'h0, seen[1:0]);
		rd(`OFS_CONFIG_CONTROL, 16'h0010);
		for (int t = 0; t < 2; t++) begin
			clear_seen();
			wr(`OFS_CONFIG_CONTROL, {11'h000, 1'b1, 2'b00, t[0], 1'b0});
			check_pin("program route", 2'b01 << t, seen[7:6]);
			rd(`OFS_CONFIG_CONTROL, {14'h0000, t[0], 1'b0});
			for (int b = 0; b < 4; b++) begin
				d = $urandom;
				sent = {sent[6:0], d};
				wr(`OFS_CONFIG_CONTROL, {14'h0000, t[0], d});
				wr(`OFS_CONFIG_CONTROL, {10'h000, 1'b1, 3'b000, t[0], d});
			end
			check_pin("clock route", 2'b01 << t, seen[3:2]);
			check_pin("shifted bits", sent[3:0], shifted[3:0]);
			wr(`OFS_CONFIG_CONTROL, {14'h0000, t[0], 1'b0});
			rd(`OFS_CONFIG_CONTROL, {11'h000, 1'b1, 2'b00, t[0], 1'b0});
			clear_seen();
			wr(`OFS_CONFIG_CONTROL, {9'h000, 1'b1, 1'b0, 1'b1, 2'b00, t[0], 1'b0});
			check_pin("reset route", {2'b01 << t, 2'b01 << t}, seen[7:4]);
		end
		end_of_test();
	end
endmodule // tb
bind correlator_control_regs correlator_control_regs_props #(.PULSE_CYCLES(PULSE_CYCLES)) props_inst (
	.clk(clk), .reset(reset), .bus_strobe_n(bus_strobe_n), .bus_ack(bus_ack), .bus_rdata_oe(bus_rdata_oe),
	.prom_reset_pulse(prom_reset_pulse), .prom_advance_pulse(prom_advance_pulse), .config_data(config_data),
	.config_clock(config_clock), .config_reset(config_reset),
	.config_done_program_line_out(config_done_program_line_out),
	.config_done_program_line_oe(config_done_program_line_oe), .sync_signal(sync_signal),
	.sync_bus_out(sync_bus_out));
`default_nettype wire
